/* File: pkg/conv_ctrl_pkg.sv */
// shared constants and types for the six-channel conversion control
package conv_ctrl_pkg;
  localparam int          NUM_PAIRS          = 3;
  localparam int          SAMPLE_WIDTH       = 16;
  localparam int          CW_WIDTH           = 32;
  // control word bit positions
  localparam int          CW_DAC_LSB         = 0;
  localparam int          CW_DAC_WIDTH       = 10;
  localparam int          CW_CLK_SEL_BIT     = 11;
  localparam int          CW_SPAN_A_BIT      = 13;
  localparam int          CW_REF_3V_BIT      = 18;
  localparam int          CW_BUSY_POL_BIT    = 20;
  localparam logic [31:0] CW_RESET           = 32'h0000_03FF;
  // timing
  localparam int          CLK_PERIOD_NS      = 8;
  localparam int          ACQ_MIN_NS         = 280;
  localparam int          BUS_TO_START_NS    = 40;
  localparam int          RD_LOW_MIN_NS      = 30;
  localparam int          RD_GAP_MIN_NS      = 10;
  localparam int          WR_LOW_MIN_NS      = 15;
  localparam int          WR_HIGH_MIN_NS     = 10;
  localparam int          ACQ_CYC            = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BUS_TO_START_CYC   =
    (BUS_TO_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RD_LOW_CYC         = (RD_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RD_GAP_CYC         = (RD_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WR_LOW_CYC         = (WR_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WR_HIGH_CYC        = (WR_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // 18.5 conversion clock cycles, counted in half cycles (both edges)
  localparam int          CONV_HALF_CYCLES   = 37;
  localparam int          INT_CLK_DIV        = 4;
  // host register map (APB byte addresses)
  localparam logic [7:0]  ADDR_CTRL          = 8'h00;
  localparam logic [7:0]  ADDR_CWORD         = 8'h04;
  localparam logic [7:0]  ADDR_STATUS        = 8'h08;
  localparam logic [7:0]  ADDR_RDATA         = 8'h0C;
  localparam int          CTRL_START_BIT     = 0;
  localparam int          CTRL_PAIRS_LSB     = 1;
  localparam int          CTRL_WRITE_BIT     = 4;
  localparam int          CTRL_READ_BIT      = 5;
  localparam int          CTRL_SW_MODE_BIT   = 6;
  localparam int          CTRL_SPAN_PIN_BIT  = 7;
  localparam int          CTRL_EXTERNAL_CONVERSION_CLOCK_EN_BIT   = 8;
  typedef enum logic [2:0] {H_IDLE, H_WR_LOW, H_WR_HIGH, H_RD_LOW, H_RD_GAP,
                            H_GUARD} host_state_type;
endpackage : conv_ctrl_pkg

/* File: pkg/conv_link_if.sv */
// parallel link between the converter and its host controller
`timescale 1ns/1ns
interface conv_link_if;
  import conv_ctrl_pkg::*;
  logic [NUM_PAIRS-1:0]    pair_sample_strobe;
  logic                    cs_n;
  logic                    rd_n;
  logic                    wr_n;
  logic [SAMPLE_WIDTH-1:0] db_host;
  logic [SAMPLE_WIDTH-1:0] db_dev;
  logic                    db_dev_oe_n;
  logic                    span_clk_pin;
  logic                    busy_pin;
  modport device (input pair_sample_strobe, cs_n, rd_n, wr_n, db_host, span_clk_pin,
                  output db_dev, db_dev_oe_n, busy_pin);
  modport host   (output pair_sample_strobe, cs_n, rd_n, wr_n, db_host, span_clk_pin,
                  input db_dev, db_dev_oe_n, busy_pin);
endinterface : conv_link_if

/* File: src/conv_device.sv */
// converter end: pair sampling, conversion sequencing, control word, parallel port
`timescale 1ns/1ns
// Summary of operation
// - six converters in three simultaneously sampled pairs
// - separate sample strobe for each pair; software mode uses the pair A strobe only
// - span 4x or 2x, pin or word
// - control bit selects 2.5 V or 3 V reference
// - span pin latched on busy fall, only while busy polarity bit is clear
// - precharge sampling capacitors before sampling
// - host allows 280 ns acquisition
// - conversion at most 1.26 us internal clock
// - external conversion clock only in software mode
// - conversion takes 18.5 conversion clock cycles
// - external clock may stop between conversions
// - external clock duty near fifty percent
// - host waits 40 ns before sample strobe
// - read strobe inside chip select, 30 ns
// - 10 ns between read accesses
// - write strobe 15 ns low, 10 high
// - reference set by 10-bit code
// - hold on strobe rise, convert next edge
// - busy up on strobe, down when done
// - no restart of a converting pair
// - control bit inverts busy polarity
module conv_device
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  // link
  conv_link_if.device                       link,
  // user side: analog samples as digital words, mode straps
  input  wire logic [2*NUM_PAIRS-1:0][15:0] analog_in,
  input  wire logic                         sw_mode,
  // user side: analog control outputs
  output logic      [NUM_PAIRS-1:0]         span_4x,
  output logic                              ref_3v,
  output logic      [CW_DAC_WIDTH-1:0]      ref_dac_code,
  output logic      [NUM_PAIRS-1:0]         precharge,
  output logic      [NUM_PAIRS-1:0]         sampling
);
  logic [CW_WIDTH-1:0]                cword_reg;
  logic [2:0]                         strb_s1_reg, strb_s2_reg, strb_s3_reg;
  logic [2:0]                         cs_sync_reg [3];
  logic [2:0]                         external_conversion_clock_sync_reg;
  logic [2:0]                         span_sync_reg;
  logic [NUM_PAIRS-1:0]               strb_rise;
  logic [NUM_PAIRS-1:0]               active_reg;
  logic [5:0]                         cnt_reg [NUM_PAIRS];
  logic [2*NUM_PAIRS-1:0][15:0]       held_reg;
  logic [2*NUM_PAIRS-1:0][15:0]       result_reg;
  logic [2:0]                         int_div_reg;
  logic                               conv_edge;
  logic                               busy_reg;
  logic                               span_pin_reg;
  logic                               cs_n_q, rd_n_q, wr_n_q, wr_n_d;
  logic [2:0]                         rd_ptr_reg;
  logic                               rd_n_d;
  logic                               use_external_conversion_clock;

  // three-stage capture of every strobe and control pin; a change counts while stages two and three differ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strb_s1_reg <= '0;
      strb_s2_reg <= '0;
      strb_s3_reg <= '0;
      cs_sync_reg <= '{3'b111, 3'b111, 3'b111};
      external_conversion_clock_sync_reg <= '0;
      span_sync_reg <= '0;
    end else if (clk_en) begin
      strb_s1_reg <= link.pair_sample_strobe;
      strb_s2_reg <= strb_s1_reg;
      strb_s3_reg <= strb_s2_reg;
      cs_sync_reg[0] <= {link.cs_n, link.rd_n, link.wr_n};
      cs_sync_reg[1] <= cs_sync_reg[0];
      cs_sync_reg[2] <= cs_sync_reg[1];
      external_conversion_clock_sync_reg <= {external_conversion_clock_sync_reg[1:0], link.span_clk_pin};
      span_sync_reg <= {span_sync_reg[1:0], link.span_clk_pin};
    end
  end
  assign {cs_n_q, rd_n_q, wr_n_q} = cs_sync_reg[1];
  assign {rd_n_d, wr_n_d}         = cs_sync_reg[2][1:0];

  // in software mode only pair A strobe starts all three pairs
  assign strb_rise = sw_mode ? {NUM_PAIRS{strb_s2_reg[0] & ~strb_s3_reg[0]}}
                             : (strb_s2_reg & ~strb_s3_reg);

  assign use_external_conversion_clock = sw_mode & cword_reg[CW_CLK_SEL_BIT];
  // both edges of the conversion clock advance the half-cycle count
  assign conv_edge = use_external_conversion_clock ? (external_conversion_clock_sync_reg[2] ^ external_conversion_clock_sync_reg[1])
                              : (int_div_reg == 3'(INT_CLK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_div_reg <= '0;
    end else if (clk_en) begin
      int_div_reg <= conv_edge ? 3'd0 : int_div_reg + 3'd1;
    end
  end

  // per-pair sequencers; a strobe on a busy pair is ignored
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        active_reg[p]        <= 1'b0;
        cnt_reg[p]           <= '0;
        held_reg[2*p]        <= '0;
        held_reg[2*p+1]      <= '0;
        result_reg[2*p]      <= '0;
        result_reg[2*p+1]    <= '0;
      end else if (clk_en) begin
        if (strb_rise[p] && !active_reg[p]) begin
          held_reg[2*p]   <= analog_in[2*p];
          held_reg[2*p+1] <= analog_in[2*p+1];
          active_reg[p]   <= 1'b1;
          cnt_reg[p]      <= '0;
        end else if (active_reg[p] && conv_edge) begin
          if (cnt_reg[p] == 6'(CONV_HALF_CYCLES - 1)) begin
            active_reg[p]     <= 1'b0;
            result_reg[2*p]   <= held_reg[2*p];
            result_reg[2*p+1] <= held_reg[2*p+1];
          end else begin
            cnt_reg[p] <= cnt_reg[p] + 6'd1;
          end
        end
      end
    end
    // last conversion clock cycle precharges the caps ahead of sampling
    assign precharge[p] = active_reg[p] && (cnt_reg[p] >= 6'(CONV_HALF_CYCLES - 2));
    assign sampling[p]  = !active_reg[p];
  end

  // busy: set on any strobe (pair A only in software mode), clear when last pair has stored results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= |strb_rise | |active_reg;
    end
  end
  assign link.busy_pin = busy_reg ^ cword_reg[CW_BUSY_POL_BIT];

  // span pin latched on busy fall when polarity bit is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_pin_reg <= 1'b0;
    end else if (clk_en) begin
      if (busy_reg && !(|strb_rise | |active_reg) && !cword_reg[CW_BUSY_POL_BIT]) begin
        span_pin_reg <= span_sync_reg[2];
      end
    end
  end

  // control word write, upper half then lower half on consecutive strobes
  logic cw_half_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cword_reg   <= CW_RESET;
      cw_half_reg <= 1'b0;
    end else if (clk_en) begin
      if (!cs_n_q && wr_n_q && !wr_n_d) begin
        cw_half_reg <= ~cw_half_reg;
        if (!cw_half_reg) begin
          cword_reg[31:16] <= link.db_host;
        end else begin
          cword_reg[15:0] <= link.db_host;
        end
      end
    end
  end

  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_span
    assign span_4x[p] = (sw_mode ? ~cword_reg[CW_SPAN_A_BIT+p] : ~span_pin_reg);
  end
  assign ref_3v       = cword_reg[CW_REF_3V_BIT];
  assign ref_dac_code = cword_reg[CW_DAC_LSB +: CW_DAC_WIDTH];

  // read: each read strobe returns the next channel word, wrapping after six
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_reg <= '0;
      link.db_dev <= '0;
    end else if (clk_en) begin
      if (|strb_rise) begin
        rd_ptr_reg <= '0;
      end else if (!cs_n_q && !rd_n_q && rd_n_d) begin
        link.db_dev <= result_reg[rd_ptr_reg];
        rd_ptr_reg  <= (rd_ptr_reg == 3'd5) ? 3'd0 : rd_ptr_reg + 3'd1;
      end
    end
  end
  assign link.db_dev_oe_n = cs_n_q | rd_n_q;
endmodule : conv_device

/* File: src/conv_host.sv */
// host end: APB registers drive strobes and parallel port sequencing
`timescale 1ns/1ns
module conv_host
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  conv_link_if.host        link
);
  host_state_type           state_reg;
  logic [31:0]              cword_reg;
  logic [NUM_PAIRS-1:0]     pairs_reg;
  logic                     start_pend_reg, wr_pend_reg, rd_pend_reg, half_reg;
  logic                     sw_span_reg, external_conversion_clock_en_reg, span_lvl_reg;
  logic [5:0]               tcnt_reg;
  logic [5:0]               acq_reg;
  logic [15:0]              rdata_reg;
  logic [2:0]               xdiv_reg;
  logic                     external_conversion_clock_reg;
  logic                     wr_acc, rd_acc;

  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr[1:0] != 2'b00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cword_reg <= CW_RESET;
      span_lvl_reg <= 1'b0;
      external_conversion_clock_en_reg <= 1'b0;
    end else if (clk_en && wr_acc) begin
      if (paddr == ADDR_CWORD) cword_reg <= pwdata;
      if (paddr == ADDR_CTRL) begin
        span_lvl_reg <= pwdata[CTRL_SPAN_PIN_BIT];
        external_conversion_clock_en_reg  <= pwdata[CTRL_EXTERNAL_CONVERSION_CLOCK_EN_BIT];
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (paddr)
        ADDR_CWORD:  prdata = cword_reg;
        ADDR_STATUS: prdata = {28'h0, link.busy_pin, start_pend_reg, wr_pend_reg,
                               state_reg != H_IDLE};
        ADDR_RDATA:  prdata = {16'h0, rdata_reg};
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end

  // external conversion clock: only toggles while a pair converts, else low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xdiv_reg <= '0;
      external_conversion_clock_reg <= 1'b0;
    end else if (clk_en) begin
      if (external_conversion_clock_en_reg && link.busy_pin != cword_reg[CW_BUSY_POL_BIT]) begin
        xdiv_reg <= (xdiv_reg == 3'd3) ? 3'd0 : xdiv_reg + 3'd1;
        if (xdiv_reg == 3'd3) external_conversion_clock_reg <= ~external_conversion_clock_reg;
      end else begin
        xdiv_reg <= '0;
        external_conversion_clock_reg <= 1'b0;
      end
    end
  end
  assign link.span_clk_pin = external_conversion_clock_en_reg ? external_conversion_clock_reg : span_lvl_reg;

  // parallel port sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= H_IDLE;
      tcnt_reg <= '0;
      acq_reg <= '0;
      start_pend_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      half_reg <= 1'b0;
      pairs_reg <= '0;
      rdata_reg <= '0;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      link.wr_n <= 1'b1;
      link.db_host <= '0;
      link.pair_sample_strobe <= '0;
    end else if (clk_en) begin
      if (acq_reg != 6'(ACQ_CYC)) acq_reg <= acq_reg + 6'd1;
      link.pair_sample_strobe <= '0;
      unique case (state_reg)
        H_IDLE: begin
          tcnt_reg <= '0;
          if (wr_pend_reg) begin
            link.cs_n <= 1'b0;
            link.wr_n <= 1'b0;
            link.db_host <= half_reg ? cword_reg[15:0] : cword_reg[31:16];
            state_reg <= H_WR_LOW;
          end else if (rd_pend_reg) begin
            link.cs_n <= 1'b0;
            link.rd_n <= 1'b0;
            state_reg <= H_RD_LOW;
          end else if (start_pend_reg && acq_reg == 6'(ACQ_CYC)) begin
            link.pair_sample_strobe <= pairs_reg;
            start_pend_reg <= 1'b0;
            acq_reg <= '0;
          end
        end
        H_WR_LOW: begin
          tcnt_reg <= tcnt_reg + 6'd1;
          if (tcnt_reg == 6'(WR_LOW_CYC + 2)) begin
            link.wr_n <= 1'b1;
            tcnt_reg <= '0;
            state_reg <= H_WR_HIGH;
          end
        end
        H_WR_HIGH: begin
          tcnt_reg <= tcnt_reg + 6'd1;
          if (tcnt_reg == 6'(WR_HIGH_CYC + 2)) begin
            half_reg <= ~half_reg;
            if (half_reg) begin
              wr_pend_reg <= 1'b0;
              link.cs_n <= 1'b1;
              tcnt_reg <= '0;
              state_reg <= H_GUARD;
            end else begin
              link.wr_n <= 1'b0;
              link.db_host <= cword_reg[15:0];
              tcnt_reg <= '0;
              state_reg <= H_WR_LOW;
            end
          end
        end
        H_RD_LOW: begin
          tcnt_reg <= tcnt_reg + 6'd1;
          if (tcnt_reg == 6'(RD_LOW_CYC + 4)) begin
            rdata_reg <= link.db_dev;
            link.rd_n <= 1'b1;
            link.cs_n <= 1'b1;
            rd_pend_reg <= 1'b0;
            tcnt_reg <= '0;
            state_reg <= H_RD_GAP;
          end
        end
        H_RD_GAP: begin
          tcnt_reg <= tcnt_reg + 6'd1;
          if (tcnt_reg == 6'(RD_GAP_CYC + 2)) begin
            tcnt_reg <= '0;
            state_reg <= H_GUARD;
          end
        end
        H_GUARD: begin
          tcnt_reg <= tcnt_reg + 6'd1;
          if (tcnt_reg == 6'(BUS_TO_START_CYC)) begin
            state_reg <= H_IDLE;
          end
        end
      endcase
      // placed last so a request landing as its predecessor retires is kept
      if (wr_acc && paddr == ADDR_CTRL) begin
        if (pwdata[CTRL_START_BIT]) begin
          start_pend_reg <= 1'b1;
          pairs_reg <= pwdata[CTRL_PAIRS_LSB +: NUM_PAIRS];
        end
        if (pwdata[CTRL_WRITE_BIT]) wr_pend_reg <= 1'b1;
        if (pwdata[CTRL_READ_BIT]) rd_pend_reg <= 1'b1;
      end
    end
  end
endmodule : conv_host

/* File: testbench/conv_link_assertions.sv */
// concurrent checks on the link between host and converter
`timescale 1ns/1ns
module conv_link_assertions
  import conv_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // link signals watched
  input wire logic [NUM_PAIRS-1:0] pair_sample_strobe,
  input wire logic                 cs_n,
  input wire logic                 rd_n,
  input wire logic                 wr_n,
  input wire logic                 busy_pin,
  input wire logic                 db_dev_oe_n
);
  logic [7:0] since_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // saturates so a long idle never wraps round into a false short gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_reg <= 8'hFF;
    end else if (|pair_sample_strobe) begin
      since_reg <= 8'h01;
    end else if (since_reg != 8'hFF) begin
      since_reg <= since_reg + 8'h01;
    end
  end

  sequence rd_low_s;
    (!rd_n) [*4];
  endsequence
  sequence wr_low_s;
    (!wr_n) [*2];
  endsequence
  sequence no_start_s;
    (pair_sample_strobe == 3'h0) [*5];
  endsequence

  rd_in_cs_a: assert property (!rd_n |-> !cs_n)
    else $error("read strobe low outside chip select");
  rd_width_a: assert property ($fell(rd_n) |-> rd_low_s)
    else $error("read strobe low too short");
  rd_gap_a: assert property ($rose(rd_n) |-> rd_n [*2])
    else $error("read accesses too close");
  wr_in_cs_a: assert property (!wr_n |-> !cs_n)
    else $error("store strobe low outside chip select");
  wr_width_a: assert property ($fell(wr_n) |-> wr_low_s)
    else $error("store strobe low too short");
  wr_high_a: assert property ($rose(wr_n) |-> wr_n [*2])
    else $error("store strobe high too short");
  start_guard_a: assert property (($rose(cs_n) || $rose(rd_n)) |-> no_start_s)
    else $error("sample strobe too soon after bus access");
  acq_space_a: assert property (|pair_sample_strobe |-> since_reg >= ACQ_CYC)
    else $error("acquisition gap too short");
  busy_start_a: assert property (|pair_sample_strobe |-> ##[1:6] $changed(busy_pin))
    else $error("busy did not follow sample strobe");
  read_drive_a: assert property ($fell(rd_n) |-> ##2 !db_dev_oe_n)
    else $error("data bus not driven during read");
  read_release_a: assert property ($rose(rd_n) |-> ##2 db_dev_oe_n)
    else $error("data bus still driven after read");
endmodule : conv_link_assertions

/* File: testbench/six_channel_sar_conversion_control_tb_top.sv */
// top bench: host and converter ends joined, driven over apb
`timescale 1ns/1ns
module six_channel_sar_conversion_control_tb_top
  import conv_ctrl_pkg::*;
;
  logic                         pclk;
  logic                         presetn;
  logic                         clk_en;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [7:0]                   paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         sw_mode;
  logic [2*NUM_PAIRS-1:0][15:0] analog_in;
  logic [NUM_PAIRS-1:0]         span_4x;
  logic                         ref_3v;
  logic [CW_DAC_WIDTH-1:0]      ref_dac_code;
  logic [NUM_PAIRS-1:0]         precharge;
  logic [NUM_PAIRS-1:0]         sampling;
  logic [31:0]                  rd_val;
  logic                         slv_err;
  logic                         lvl;
  int                           err_count;
  int                           compares;
  int                           cycles;

  conv_link_if link ();

  conv_host i_conv_host (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link)
  );
  conv_device i_conv_device (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .link(link), .analog_in(analog_in),
    .sw_mode(sw_mode), .span_4x(span_4x), .ref_3v(ref_3v), .ref_dac_code(ref_dac_code),
    .precharge(precharge), .sampling(sampling)
  );
  conv_link_assertions i_conv_link_assertions (
    .pclk(pclk), .presetn(presetn), .pair_sample_strobe(link.pair_sample_strobe),
    .cs_n(link.cs_n), .rd_n(link.rd_n), .wr_n(link.wr_n), .busy_pin(link.busy_pin),
    .db_dev_oe_n(link.db_dev_oe_n)
  );

  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // a hang in any wait ends here rather than running forever
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_val  = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd_val[2:0] !== 3'h0 && n < 500);
    chk(n < 500, 32'h1);
  endtask : wait_idle

  task automatic set_word(input logic [31:0] w);
    apb(1'b1, ADDR_CWORD, w);
    apb(1'b0, ADDR_CWORD, 32'h0);
    chk(rd_val, w);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_WRITE_BIT);
    wait_idle();
    // device sees link edges through a three-flop synchroniser
    repeat (4) @(posedge pclk);
    chk(ref_dac_code, w[9:0]);
    chk(ref_3v, w[CW_REF_3V_BIT]);
    // a set span bit selects the 2x span
    chk(span_4x, {~w[15:13]});
    chk(link.busy_pin, w[CW_BUSY_POL_BIT]);
  endtask : set_word

  task automatic conv(input logic [2:0] mask, input logic [31:0] extra,
                      input logic [2:0] samp, input int lo, input int hi);
    logic idle;
    logic pre_seen;
    int   n;
    logic [15:0] base;
    idle     = link.busy_pin;
    // a fresh base per run so stale results from an earlier run cannot pass
    base     = {4'hA, 8'(cycles >> 2), 4'h0};
    pre_seen = 1'b0;
    n        = 0;
    for (int k = 0; k < 6; k++) begin
      analog_in[k] <= base + 16'(k);
    end
    apb(1'b1, ADDR_CTRL, extra | (32'(mask) << CTRL_PAIRS_LSB) | (32'h1 << CTRL_START_BIT));
    while (link.pair_sample_strobe === 3'h0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(link.pair_sample_strobe, mask);
    n = 0;
    while (link.busy_pin === idle && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(n < 20, 32'h1);
    while (link.busy_pin !== idle && n < 2000) begin
      @(posedge pclk);
      n++;
      if (precharge[0] === 1'b1) begin
        pre_seen = 1'b1;
      end
      // inputs move after the hold edge; results must not follow them
      if (n == 20) begin
        for (int k = 0; k < 6; k++) begin
          analog_in[k] <= 16'h5000 + 16'(k);
        end
      end
      if (n == 40) begin
        chk(sampling, samp);
      end
    end
    chk(n >= lo && n <= hi, 32'h1);
    chk(pre_seen, 1'b1);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_READ_BIT);
      wait_idle();
      apb(1'b0, ADDR_RDATA, 32'h0);
      chk(rd_val[15:0], base + 16'(k));
    end
  endtask : conv

  initial begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    clk_en    = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    sw_mode   = 1'b1;
    analog_in = '0;
    err_count = 0;
    compares  = 0;
    cycles    = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(ref_dac_code, CW_RESET[9:0]);
    chk(link.busy_pin, 1'b0);
    chk({link.cs_n, link.rd_n, link.wr_n}, 3'h7);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd_val, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_val, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk(slv_err, 1'b1);
    set_word(32'h0004_A155);
    set_word(32'h0010_40CC);
    // software mode: the pair A strobe starts every pair
    conv(3'h1, 32'h0, 3'h0, 148, 157);
    set_word(32'h0000_0BFF);
    // a frozen host drops the write, so the word reads back unchanged
    clk_en <= 1'b0;
    apb(1'b1, ADDR_CWORD, 32'h0000_1234);
    apb(1'b0, ADDR_CWORD, 32'h0);
    chk(rd_val, 32'h0000_0BFF);
    clk_en <= 1'b1;
    sw_mode <= 1'b0;
    // hardware mode ignores the clock select bit and keeps the internal clock
    for (int i = 0; i < 3; i++) begin
      lvl = (i == 1);
      conv(3'((1 << (i + 1)) - 1), 32'(lvl) << CTRL_SPAN_PIN_BIT,
           ~3'((1 << (i + 1)) - 1), 148, 157);
      chk(span_4x, {3{~lvl}});
      apb(1'b1, ADDR_CTRL, 32'(!lvl) << CTRL_SPAN_PIN_BIT);
      repeat (4) @(posedge pclk);
      chk(span_4x, {3{~lvl}});
    end
    sw_mode <= 1'b1;
    // 37 external half-periods of 4 cycles each, plus start and sync latency
    conv(3'h1, 32'h1 << CTRL_EXTERNAL_CONVERSION_CLOCK_EN_BIT, 3'h0, 150, 160);
    conclude();
  end
endmodule : six_channel_sar_conversion_control_tb_top
